// ### rtl/sbtc_top.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Wide bit selects buffered 16-bit access
// - Select field assigns time base per unit
// - Prescale field divides by 1,2,4,8
// - Sync-disable bit chooses async or sync counting
// - Internal source ignores sync-disable bit
// - External edges counted after first falling edge
// - Internal source counts every fourth core clock
// - Run bit enables counting, else hold
// - Oscillator enable forces pins input, read zero
// - Low-byte read copies high byte into buffer
// - High write buffers, low write loads both
// - Wide mode high byte only via buffer
// - Only low-byte write clears prescaler
// - Count wraps to zero and sets flag
// - Enable bit gates the overflow interrupt
// - Count seen as high and low bytes
// - Special-event compare match clears the count, except in async mode
// - Software write beats special-event clear
// - Special-event clear never sets the flag
module sbtc_top (
   // Clock and reset
   input  wire logic                              CORE_CLK,
   input  wire logic                              SYS_RST,
   // Register port
   input  wire sbtc_pkg::sbtc_bus_t               BUS,
   output logic [sbtc_pkg::DATA_W-1:0]            REG_RDATA,
   // Count sources
   input  wire logic                              EXT_COUNT_IN,
   input  wire logic                              LP_OSC_IN,
   input  wire logic [sbtc_pkg::DATA_W-1:0]       COMPANION_CTRL,
   // Shared port pins
   input  wire logic [1:0]                        PORTC_PIN_IN,
   input  wire logic [1:0]                        PORTC_DIRECTION,
   output logic [1:0]                             PORTC_READ,
   output logic [1:0]                             PORTC_DIR_EFF,
   // Capture/compare units
   input  wire logic [3:0]                        CCP1_MODE,
   input  wire logic                              CCP1_MATCH,
   input  wire logic [3:0]                        CCP2_MODE,
   input  wire logic                              CCP2_MATCH,
   output logic                                   CCP1_USES_THIS,
   output logic                                   CCP2_USES_THIS,
   // Status
   output logic [sbtc_pkg::CNT_W-1:0]             COUNT_VALUE,
   output logic                                   OVERFLOW_PULSE,
   output logic                                   IRQ
);
   sbtc_pkg::sbtc_state_t q;
   sbtc_pkg::sbtc_state_t d;
   logic                  lp_en;
   logic                  src_lvl;
   logic                  cs;
   logic                  run;
   logic                  wide;
   logic                  async_mode;
   logic                  inst_tick;
   logic                  ext_edge;
   logic                  src_tick;
   logic                  inc;
   logic                  wrap;
   logic                  spec_req;
   logic                  wr_lo;
   logic                  wr_hi;
   logic [2:0]            pre_last;
   logic [1:0]            ps;

   function automatic logic is_special(input logic [3:0] mode);
      is_special = (mode == sbtc_pkg::SPECIAL_MODE);
   endfunction : is_special

   assign lp_en      = COMPANION_CTRL[sbtc_pkg::OSC_EN_BIT];
   assign cs         = q.ctrl[sbtc_pkg::CTRL_CS];
   assign run        = q.ctrl[sbtc_pkg::CTRL_RUN];
   assign wide       = q.ctrl[sbtc_pkg::CTRL_WIDE];
   assign async_mode = cs & q.ctrl[sbtc_pkg::CTRL_SYNC_DIS];
   assign ps         = {q.ctrl[sbtc_pkg::CTRL_PS_HI], q.ctrl[sbtc_pkg::CTRL_PS_LO]};
   assign src_lvl    = lp_en ? q.osc_s2 : q.ext_s2;
   assign inst_tick  = (q.div == sbtc_pkg::INST_LAST);
   assign ext_edge   = cs & q.armed & src_lvl & ~q.prev;
   assign wr_lo      = BUS.wr & (BUS.addr == sbtc_pkg::REG_CNT_LO);
   assign wr_hi      = BUS.wr & (BUS.addr == sbtc_pkg::REG_CNT_HI);

   // Time base routing
   assign CCP1_USES_THIS = q.ctrl[sbtc_pkg::CTRL_SEL_HI];
   assign CCP2_USES_THIS = q.ctrl[sbtc_pkg::CTRL_SEL_HI] | q.ctrl[sbtc_pkg::CTRL_SEL_LO];
   assign spec_req = (CCP1_MATCH & is_special(CCP1_MODE) & CCP1_USES_THIS)
                   | (CCP2_MATCH & is_special(CCP2_MODE) & CCP2_USES_THIS);

   // Source tick: internal cycle, raw edge, or edge aligned to the cycle
   always_comb begin
      if (!cs) begin
         src_tick = inst_tick;
      end else if (async_mode) begin
         src_tick = ext_edge;
      end else begin
         src_tick = inst_tick & (q.pend | ext_edge);
      end
   end

   always_comb begin
      case (ps)
         2'h0:    pre_last = sbtc_pkg::PRE_LAST_1;
         2'h1:    pre_last = sbtc_pkg::PRE_LAST_2;
         2'h2:    pre_last = sbtc_pkg::PRE_LAST_4;
         2'h3:    pre_last = sbtc_pkg::PRE_LAST_8;
         default: pre_last = sbtc_pkg::PRE_LAST_1;
      endcase
   end

   assign inc  = run & src_tick & (q.pre == pre_last);
   assign wrap = inc & (q.cnt == sbtc_pkg::CNT_MAX);

   always_comb begin
      d     = q;
      d.ovf = 1'b0;
      // Pin synchronisers
      d.ext_s1 = EXT_COUNT_IN;
      d.ext_s2 = q.ext_s1;
      d.osc_s1 = LP_OSC_IN;
      d.osc_s2 = q.osc_s1;
      d.pc_s1  = PORTC_PIN_IN;
      d.pc_s2  = q.pc_s1;
      // Instruction cycle divider
      d.div = inst_tick ? 2'h0 : q.div + 2'h1;
      // Edge qualification
      d.prev = src_lvl;
      if (!cs) begin
         d.armed = 1'b0;
      end else if (q.prev && !src_lvl) begin
         d.armed = 1'b1;
      end
      if (!cs || inst_tick) begin
         d.pend = 1'b0;
      end
      if (cs && ext_edge && !inst_tick) begin
         d.pend = 1'b1;
      end
      // Prescaler and count
      if (run && src_tick) begin
         d.pre = inc ? 3'h0 : q.pre + 3'h1;
      end
      if (inc) begin
         d.cnt = q.cnt + 16'h0001;
      end
      if (wrap) begin
         d.flag = 1'b1;
         d.ovf  = 1'b1;
      end
      if (spec_req && !async_mode) begin
         d.cnt = '0;
      end
      // Software writes come last so they win, except that a wrap still sets the flag
      if (BUS.wr) begin
         case (BUS.addr)
            sbtc_pkg::REG_CTRL: begin
               d.ctrl = BUS.wdata;
            end
            sbtc_pkg::REG_CNT_LO: begin
               d.cnt[7:0] = BUS.wdata;
               if (wide) begin
                  d.cnt[15:8] = q.hbuf;
               end
               d.pre = 3'h0;
            end
            sbtc_pkg::REG_CNT_HI: begin
               if (wide) begin
                  d.hbuf = BUS.wdata;
               end else begin
                  d.cnt[15:8] = BUS.wdata;
               end
            end
            sbtc_pkg::REG_IRQ_FLAG: begin
               d.flag = BUS.wdata[sbtc_pkg::IRQ_BIT] | wrap;
            end
            sbtc_pkg::REG_IRQ_EN: begin
               d.ien = BUS.wdata[sbtc_pkg::IRQ_BIT];
            end
            default: begin
               d.ien = q.ien;
            end
         endcase
      end
      // Reads
      d.rdata = '0;
      if (BUS.rd) begin
         case (BUS.addr)
            sbtc_pkg::REG_CTRL: begin
               d.rdata = q.ctrl;
            end
            sbtc_pkg::REG_CNT_LO: begin
               d.rdata = q.cnt[7:0];
               if (wide) begin
                  d.hbuf = q.cnt[15:8];
               end
            end
            sbtc_pkg::REG_CNT_HI: begin
               d.rdata = wide ? q.hbuf : q.cnt[15:8];
            end
            sbtc_pkg::REG_IRQ_FLAG: begin
               d.rdata[sbtc_pkg::IRQ_BIT] = q.flag;
            end
            sbtc_pkg::REG_IRQ_EN: begin
               d.rdata[sbtc_pkg::IRQ_BIT] = q.ien;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
      // Shared pins
      d.pin_rd  = lp_en ? 2'h0 : q.pc_s2;
      d.dir_eff = lp_en ? 2'h3 : PORTC_DIRECTION;
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q <= sbtc_pkg::ST_RST;
      end else begin
         q <= d;
      end
   end

   assign REG_RDATA      = q.rdata;
   assign COUNT_VALUE    = q.cnt;
   assign OVERFLOW_PULSE = q.ovf;
   assign PORTC_READ     = q.pin_rd;
   assign PORTC_DIR_EFF  = q.dir_eff;
   assign IRQ            = q.flag & q.ien;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_no_inc3;
      !inc [*3];
   endsequence

   sequence s_quiet;
      !BUS.wr && !spec_req;
   endsequence

   AST_RUN_HOLD: assert property ((!run and s_quiet) |=> q.cnt == $past(q.cnt))
      else $error("count moved while stopped");
   AST_WRAP_FLAG: assert property ((wrap and s_quiet) |=> q.flag && q.cnt == 16'h0000 && OVERFLOW_PULSE)
      else $error("wrap did not clear count and set flag");
   AST_IRQ_GATE: assert property (q.flag && !q.ien |-> !IRQ)
      else $error("interrupt raised while disabled");
   AST_WIDE_LATCH: assert property (BUS.rd && BUS.addr == sbtc_pkg::REG_CNT_LO && wide
      |=> q.hbuf == $past(q.cnt[15:8]))
      else $error("low read did not latch high byte");
   AST_WIDE_WRITE: assert property (wr_lo && wide
      |=> q.cnt == {$past(q.hbuf), $past(BUS.wdata)})
      else $error("low write did not load buffered high byte");
   AST_PRE_CLEAR: assert property (wr_lo |=> q.pre == 3'h0)
      else $error("prescaler not cleared by low write");
   AST_SPEC_RESET: assert property (spec_req && !async_mode && !BUS.wr |=> q.cnt == 16'h0000 && !OVERFLOW_PULSE)
      else $error("special event did not clear count");
   AST_INT_RATE: assert property (inc && !cs |=> s_no_inc3)
      else $error("internal count faster than every fourth clock");
   AST_PIN_ZERO: assert property (lp_en ##1 lp_en |-> PORTC_READ == 2'h0 && PORTC_DIR_EFF == 2'h3)
      else $error("pins not forced while oscillator enabled");
endmodule : sbtc_top

// ### rtl/sbtc_pkg.sv
package sbtc_pkg;
   // Register bus widths
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL     = 3'h0;
   localparam logic [ADDR_W-1:0] REG_CNT_LO   = 3'h1;
   localparam logic [ADDR_W-1:0] REG_CNT_HI   = 3'h2;
   localparam logic [ADDR_W-1:0] REG_IRQ_FLAG = 3'h3;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 3'h4;

   // Control register fields, then the interrupt bit and the companion oscillator enable bit
   localparam int CTRL_WIDE     = 7;
   localparam int CTRL_SEL_HI   = 6;
   localparam int CTRL_PS_HI    = 5;
   localparam int CTRL_PS_LO    = 4;
   localparam int CTRL_SEL_LO   = 3;
   localparam int CTRL_SYNC_DIS = 2;
   localparam int CTRL_CS       = 1;
   localparam int CTRL_RUN      = 0;
   localparam int IRQ_BIT       = 1;
   localparam int OSC_EN_BIT    = 3;

   // Values
   localparam logic [DATA_W-1:0] CTRL_RST      = 8'h00;
   localparam logic [3:0]        SPECIAL_MODE  = 4'hb;
   localparam logic [1:0]        INST_LAST     = 2'h3;
   localparam logic [CNT_W-1:0]  CNT_MAX       = 16'hffff;
   localparam logic [2:0]        PRE_LAST_1    = 3'h0;
   localparam logic [2:0]        PRE_LAST_2    = 3'h1;
   localparam logic [2:0]        PRE_LAST_4    = 3'h3;
   localparam logic [2:0]        PRE_LAST_8    = 3'h7;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } sbtc_bus_t;

   typedef struct packed {
      logic [DATA_W-1:0] ctrl;
      logic [CNT_W-1:0]  cnt;
      logic [DATA_W-1:0] hbuf;
      logic [2:0]        pre;
      logic [1:0]        div;
      logic              flag;
      logic              ien;
      logic              ovf;
      logic [DATA_W-1:0] rdata;
      logic              ext_s1;
      logic              ext_s2;
      logic              osc_s1;
      logic              osc_s2;
      logic [1:0]        pc_s1;
      logic [1:0]        pc_s2;
      logic [1:0]        pin_rd;
      logic [1:0]        dir_eff;
      logic              prev;
      logic              armed;
      logic              pend;
   } sbtc_state_t;

   localparam sbtc_state_t ST_RST = '0;
endpackage : sbtc_pkg

// ### tb/sbtc_ext_src.sv
`timescale 1ns/1ps
module sbtc_ext_src (
   // Clock
   input  wire logic clk,
   // Count sources
   output logic      ext_o,
   output logic      osc_o
);
   initial begin
      ext_o = 1'b0;
      osc_o = 1'b0;
   end
   // Lines rest low between bursts, pulses long enough for the synchronisers
   task automatic burst(input bit osc, input int n);
      repeat (n) begin
         repeat (8) @(posedge clk);
         if (osc) osc_o <= 1'b1; else ext_o <= 1'b1;
         repeat (8) @(posedge clk);
         if (osc) osc_o <= 1'b0; else ext_o <= 1'b0;
      end
   endtask : burst
endmodule : sbtc_ext_src

// ### tb/sbtc_top_test.sv
`timescale 1ns/1ps
module sbtc_top_test;
   logic                 clk, rst, m1, m2;
   sbtc_pkg::sbtc_bus_t  bus;
   logic [7:0]           rdata, comp, rv;
   logic [1:0]           pin, dir, prd, pdir;
   logic [3:0]           md1, md2;
   logic                 use1, use2, ovf, irq, ext, osc;
   logic [15:0]          cnt, c0;
   int                   error_cnt, comparisons;

   sbtc_ext_src u_src (.clk(clk), .ext_o(ext), .osc_o(osc));
   sbtc_top u_dut (.CORE_CLK(clk), .SYS_RST(rst), .BUS(bus), .REG_RDATA(rdata), .EXT_COUNT_IN(ext),
      .LP_OSC_IN(osc), .COMPANION_CTRL(comp), .PORTC_PIN_IN(pin), .PORTC_DIRECTION(dir),
      .PORTC_READ(prd), .PORTC_DIR_EFF(pdir), .CCP1_MODE(md1), .CCP1_MATCH(m1), .CCP2_MODE(md2),
      .CCP2_MATCH(m2), .CCP1_USES_THIS(use1), .CCP2_USES_THIS(use2), .COUNT_VALUE(cnt),
      .OVERFLOW_PULSE(ovf), .IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Count advance over a window of n edges
   task automatic rate(input int n, input logic [15:0] exp);
      c0 = cnt;
      repeat (n) @(posedge clk);
      #1 chk(cnt - c0, exp);
   endtask : rate

   initial begin
      error_cnt = 0;
      comparisons = 0;
      rst = 1'b1;
      bus = '0;
      comp = 8'h00;
      pin = 2'b10;
      dir = 2'b00;
      md1 = 4'hb;
      md2 = 4'ha;
      m1 = 1'b0;
      m2 = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(sbtc_pkg::REG_CTRL, rv);
      chk(rv, 8'h00);
      rd(3'h5, rv);
      chk(rv, 8'h00);
      wr(sbtc_pkg::REG_CTRL, 8'h01);
      rate(40, 16'h000a);
      wr(sbtc_pkg::REG_CTRL, 8'h05);
      rate(40, 16'h000a);
      for (int ps = 0; ps < 4; ps++) begin
         wr(sbtc_pkg::REG_CTRL, 8'h01 | 8'(ps << 4));
         rate(128, 16'(32 >> ps));
      end
      wr(sbtc_pkg::REG_CTRL, 8'h00);
      rate(40, 16'h0000);
      // Buffered access
      wr(sbtc_pkg::REG_CTRL, 8'h80);
      c0 = cnt;
      wr(sbtc_pkg::REG_CNT_HI, 8'h12);
      chk(cnt, c0);
      wr(sbtc_pkg::REG_CNT_LO, 8'h34);
      chk(cnt, 16'h1234);
      wr(sbtc_pkg::REG_CNT_HI, 8'h77);
      chk(cnt, 16'h1234);
      rd(sbtc_pkg::REG_CNT_LO, rv);
      chk(rv, 8'h34);
      rd(sbtc_pkg::REG_CNT_HI, rv);
      chk(rv, 8'h12);
      wr(sbtc_pkg::REG_CTRL, 8'h00);
      wr(sbtc_pkg::REG_CNT_HI, 8'h56);
      chk(cnt, 16'h5634);
      // Time base selection for each code of the field
      for (int s = 0; s < 4; s++) begin
         wr(sbtc_pkg::REG_CTRL, {1'b0, s[1], 2'b00, s[0], 3'b000});
         chk({use1, use2}, {s[1], s[1] | s[0]});
      end
      // Special event clear, only on mode 1011
      wr(sbtc_pkg::REG_CTRL, 8'h40);
      @(posedge clk);
      m2 <= 1'b1;
      @(posedge clk);
      m2 <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(cnt, 16'h5634);
      @(posedge clk);
      m1 <= 1'b1;
      @(posedge clk);
      m1 <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(cnt, 16'h0000);
      rd(sbtc_pkg::REG_IRQ_FLAG, rv);
      chk(rv, 8'h00);
      // Write and special event in one cycle
      wr(sbtc_pkg::REG_CTRL, 8'hc0);
      wr(sbtc_pkg::REG_CNT_HI, 8'hab);
      @(posedge clk);
      bus <= '{addr: sbtc_pkg::REG_CNT_LO, wdata: 8'hcd, wr: 1'b1, rd: 1'b0};
      m1 <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      m1 <= 1'b0;
      #1 chk(cnt, 16'habcd);
      // Wrap and interrupt flag
      wr(sbtc_pkg::REG_CNT_HI, 8'hff);
      wr(sbtc_pkg::REG_CNT_LO, 8'hfd);
      wr(sbtc_pkg::REG_CTRL, 8'h01);
      for (int i = 0; i <= 40 && ovf !== 1'b1; i++) begin
         if (i == 40) begin
            chk(1'b0, 1'b1);
            end_sim();
         end
         @(posedge clk);
         #1;
      end
      chk(cnt, 16'h0000);
      wr(sbtc_pkg::REG_CTRL, 8'h00);
      rd(sbtc_pkg::REG_IRQ_FLAG, rv);
      chk(rv, 8'h02);
      chk(irq, 1'b0);
      wr(sbtc_pkg::REG_IRQ_EN, 8'h02);
      chk(irq, 1'b1);
      wr(sbtc_pkg::REG_IRQ_FLAG, 8'h00);
      chk(irq, 1'b0);
      // External edges: first rise uncounted until a fall is seen
      wr(sbtc_pkg::REG_CTRL, 8'h03);
      c0 = cnt;
      u_src.burst(1'b0, 4);
      repeat (16) @(posedge clk);
      #1 chk(cnt - c0, 16'h0003);
      // Core clock never comes from the oscillator here
      wr(sbtc_pkg::REG_CTRL, 8'h07);
      c0 = cnt;
      u_src.burst(1'b0, 4);
      repeat (16) @(posedge clk);
      #1 chk(cnt - c0, 16'h0004);
      @(posedge clk);
      comp <= 8'h08;
      #1 c0 = cnt;
      u_src.burst(1'b1, 3);
      repeat (16) @(posedge clk);
      #1 chk(cnt - c0, 16'h0003);
      chk(prd, 2'b00);
      chk(pdir, 2'b11);
      @(posedge clk);
      comp <= 8'h00;
      repeat (4) @(posedge clk);
      #1 chk(prd, 2'b10);
      chk(pdir, 2'b00);
      end_sim();
   end
endmodule : sbtc_top_test
